// ### hw/busoff_ctrl_defines.svh
// register offsets, field positions, fault confinement encodings and timing counts for the bus-off control slice
`ifndef BUSOFF_CTRL_DEFINES_SVH
`define BUSOFF_CTRL_DEFINES_SVH

// register byte offsets
`define OFS_MODULE_CONFIG 12'h000
`define OFS_CONTROL 12'h004
`define OFS_ERROR_STATUS 12'h008
`define OFS_IRQ_STATUS 12'h00c
`define OFS_IRQ_MASK 12'h010

// module_config_reg fields
`define MODCFG_SOFT_RST_BIT 0
`define MODCFG_ERRATUM_BIT 1
// control register fields
`define CTRL_BUSOFF_MSK_BIT 15
// error_status_reg fields
`define ERRSTAT_FLT_LO 4
`define ERRSTAT_BUSOFF_FLAG_BIT 2
// irq status/mask fields
`define IRQ_BUSOFF_BIT 0
`define IRQ_RESET_DONE_BIT 1

// fault confinement encodings
`define FLT_ERROR_ACTIVE 2'h0
`define FLT_ERROR_PASSIVE 2'h1
`define FLT_BUS_OFF 2'h3

// timing counts
`define SOFT_RESET_CYCLES 4'h8
`define GLITCH_DELAY_CYCLES 4'h2
`define GLITCH_HOLD_CYCLES 4'h3

`endif

// ### hw/busoff_ctrl_pkg.sv
// types shared by the bus-off control slice
package busoff_ctrl_pkg;
   typedef logic [1:0] fault_conf_t;

   typedef enum logic [1:0] {
      SR_IDLE = 2'b00,
      SR_RUN = 2'b01,
      SR_GLITCH_WAIT = 2'b10,
      SR_GLITCH = 2'b11
   } soft_reset_state_t;
endpackage

// ### hw/apb_reg_slave.sv
// apb slave front end: one-wait-free decode into read and write strobes
`timescale 1ns/1ps
`include "busoff_ctrl_defines.svh"
module apb_reg_slave #(
   parameter int AddrWidth = 12
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // apb
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [AddrWidth-1:0] paddr,
   output logic pready,
   output logic pslverr,
   // decoded access
   output logic wrStrobe,
   output logic rdStrobe,
   output logic [2:0] regIndex,
   output logic regHit
);
   // elaboration check: the word index decode needs address bits 4:2
   if (AddrWidth < 5) begin
      $error("apb_reg_slave: AddrWidth too small");
   end

   wire access = psel && penable;
   wire aligned = (paddr[1:0] == 2'b00);
   wire inRange = (paddr[AddrWidth-1:2] <= (`OFS_IRQ_MASK >> 2));

   // zero-wait answer; unmapped or unaligned words signal an error
   assign pready = 1'b1;
   assign regHit = aligned && inRange;
   assign pslverr = access && !regHit;
   assign regIndex = paddr[4:2];
   assign wrStrobe = access && pwrite && regHit;
   assign rdStrobe = access && !pwrite && regHit;

   // rst kept on the port so the front end can later gain state
   wire unusedRst = rst;
endmodule

// ### hw/soft_reset_seq.sv
// soft-reset sequencer driving the fault confinement state through reset
`timescale 1ns/1ps
`include "busoff_ctrl_defines.svh"
module soft_reset_seq (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // control
   input wire logic start,
   input wire logic erratumMode,
   // status
   output logic busy,
   output logic done,
   output logic glitch
);
   busoff_ctrl_pkg::soft_reset_state_t state_q, state_d;
   logic [3:0] cnt_q, cnt_d;

   // next state: reset runs a fixed time, then optionally the bus-off echo
   always_comb begin
      state_d = state_q;
      cnt_d = cnt_q;
      done = 1'b0;
      unique case (state_q)
         busoff_ctrl_pkg::SR_IDLE: begin
            if (start) begin
               state_d = busoff_ctrl_pkg::SR_RUN;
               cnt_d = `SOFT_RESET_CYCLES;
            end
         end
         busoff_ctrl_pkg::SR_RUN: begin
            cnt_d = cnt_q - 4'h1;
            if (cnt_q == 4'h1) begin
               done = 1'b1;
               if (erratumMode) begin
                  state_d = busoff_ctrl_pkg::SR_GLITCH_WAIT;
                  cnt_d = `GLITCH_DELAY_CYCLES;
               end else begin
                  state_d = busoff_ctrl_pkg::SR_IDLE;
               end
            end
         end
         busoff_ctrl_pkg::SR_GLITCH_WAIT: begin
            cnt_d = cnt_q - 4'h1;
            if (cnt_q == 4'h1) begin
               state_d = busoff_ctrl_pkg::SR_GLITCH;
               cnt_d = `GLITCH_HOLD_CYCLES;
            end
         end
         busoff_ctrl_pkg::SR_GLITCH: begin
            cnt_d = cnt_q - 4'h1;
            if (cnt_q == 4'h1) state_d = busoff_ctrl_pkg::SR_IDLE;
         end
      endcase
      // a request during the echo restarts the reset instead of being lost
      if (start && state_q != busoff_ctrl_pkg::SR_RUN) begin
         state_d = busoff_ctrl_pkg::SR_RUN;
         cnt_d = `SOFT_RESET_CYCLES;
      end
   end

   assign busy = (state_q == busoff_ctrl_pkg::SR_RUN);
   assign glitch = (state_q == busoff_ctrl_pkg::SR_GLITCH);

   always_ff @(posedge clk) begin
      if (rst) begin
         state_q <= busoff_ctrl_pkg::SR_IDLE;
         cnt_q <= 4'h0;
      end else begin
         state_q <= state_d;
         cnt_q <= cnt_d;
      end
   end
endmodule

// ### hw/can_busoff_soft_reset_control.sv
// bus-off interrupt and soft-reset control slice of a can controller
//
// Our own choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "busoff_ctrl_defines.svh"
module can_busoff_soft_reset_control (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // from the protocol engine and the chip
   input wire logic busOffEnter,
   input wire logic errorPassive,
   input wire logic globalSoftReset,
   // to the processor
   output logic busOffIrq,
   output logic irq
);
   logic wrStrobe, rdStrobe, regHit;
   logic [2:0] regIndex;
   logic seqBusy, seqDone, seqGlitch;
   logic glitchLast_q;

   logic softRst_q, softRst_d;
   logic erratumMode_q;
   logic busOffMask_q;
   logic busOffFlag_q, busOffFlag_d;
   busoff_ctrl_pkg::fault_conf_t faultConf_q, faultConf_d;
   logic [1:0] irqStatus_q, irqStatus_d;
   logic [1:0] irqMask_q;
   logic [31:0] rdata_q;

   apb_reg_slave #(.AddrWidth(12)) u_apb (
      .clk(clk),
      .rst(rst),
      .psel(psel),
      .penable(penable),
      .pwrite(pwrite),
      .paddr(paddr),
      .pready(pready),
      .pslverr(pslverr),
      .wrStrobe(wrStrobe),
      .rdStrobe(rdStrobe),
      .regIndex(regIndex),
      .regHit(regHit)
   );

   // register selects
   wire selModCfg = (regIndex == 3'(`OFS_MODULE_CONFIG >> 2));
   wire selCtrl = (regIndex == 3'(`OFS_CONTROL >> 2));
   wire selErrStat = (regIndex == 3'(`OFS_ERROR_STATUS >> 2));
   wire selIrqSt = (regIndex == 3'(`OFS_IRQ_STATUS >> 2));
   wire selIrqMsk = (regIndex == 3'(`OFS_IRQ_MASK >> 2));

   wire wrModCfg = wrStrobe && selModCfg;
   wire wrCtrl = wrStrobe && selCtrl;
   wire wrErrStat = wrStrobe && selErrStat;
   wire wrIrqMsk = wrStrobe && selIrqMsk;
   wire rdIrqSt = rdStrobe && selIrqSt;

   // a soft reset starts from the register bit or the chip-wide request
   wire softReq = (wrModCfg && pwdata[`MODCFG_SOFT_RST_BIT]) || globalSoftReset;
   wire seqStart = softReq && !softRst_q;
   wire flagClearWr = wrErrStat && pwdata[`ERRSTAT_BUSOFF_FLAG_BIT];

   soft_reset_seq u_seq (
      .clk(clk),
      .rst(rst),
      .start(seqStart),
      .erratumMode(erratumMode_q),
      .busy(seqBusy),
      .done(seqDone),
      .glitch(seqGlitch)
   );

   // soft-reset bit holds until the sequencer reports completion
   always_comb begin
      softRst_d = softRst_q;
      if (seqStart) softRst_d = 1'b1;
      if (seqDone) softRst_d = 1'b0;
   end

   // fault confinement: soft reset forces error-active, the echo forces bus-off
   always_comb begin
      faultConf_d = faultConf_q;
      if (seqBusy || seqDone) begin
         faultConf_d = `FLT_ERROR_ACTIVE;
      end else if (seqGlitch) begin
         faultConf_d = `FLT_BUS_OFF;
      end else if (busOffEnter) begin
         faultConf_d = `FLT_BUS_OFF;
      end else if (faultConf_q == `FLT_BUS_OFF && glitchLast_q) begin
         // only the echo settles by itself; a real bus-off waits for a soft reset
         faultConf_d = `FLT_ERROR_ACTIVE;
      end else if (faultConf_q != `FLT_BUS_OFF) begin
         faultConf_d = errorPassive ? `FLT_ERROR_PASSIVE : `FLT_ERROR_ACTIVE;
      end
   end

   // bus-off entry edge; set beats a simultaneous write-one clear
   wire enterBusOff = (faultConf_d == `FLT_BUS_OFF) && (faultConf_q != `FLT_BUS_OFF);
   wire flagSet = (busOffEnter && !seqBusy) || (seqGlitch && erratumMode_q);
   always_comb begin
      busOffFlag_d = busOffFlag_q;
      if (flagClearWr) busOffFlag_d = 1'b0;
      if (flagSet) busOffFlag_d = 1'b1;
   end

   // interrupt status: sticky events, cleared by reading the register
   // only the bits the read returned are cleared, so an event in the setup cycle survives
   wire [1:0] irqEvents = {seqDone, enterBusOff};
   always_comb begin
      irqStatus_d = irqStatus_q;
      if (rdIrqSt) irqStatus_d = irqStatus_q & ~rdata_q[1:0];
      irqStatus_d = irqStatus_d | irqEvents;
   end

   // control registers
   always_ff @(posedge clk) begin
      if (rst) begin
         busOffMask_q <= 1'b0;
         erratumMode_q <= 1'b0;
         irqMask_q <= 2'b00;
      end else begin
         if (wrCtrl) busOffMask_q <= pwdata[`CTRL_BUSOFF_MSK_BIT];
         if (wrModCfg) erratumMode_q <= pwdata[`MODCFG_ERRATUM_BIT];
         if (wrIrqMsk) irqMask_q <= pwdata[1:0];
      end
   end

   // status state
   always_ff @(posedge clk) begin
      if (rst) begin
         softRst_q <= 1'b0;
         glitchLast_q <= 1'b0;
         busOffFlag_q <= 1'b0;
         faultConf_q <= `FLT_ERROR_ACTIVE;
         irqStatus_q <= 2'b00;
      end else begin
         softRst_q <= softRst_d;
         glitchLast_q <= seqGlitch;
         busOffFlag_q <= busOffFlag_d;
         faultConf_q <= faultConf_d;
         irqStatus_q <= irqStatus_d;
      end
   end

   // read mux, registered so that prdata comes from a flip-flop
   logic [31:0] rdMux;
   always_comb begin
      rdMux = 32'h0000_0000;
      if (selModCfg) begin
         rdMux[`MODCFG_SOFT_RST_BIT] = softRst_q;
         rdMux[`MODCFG_ERRATUM_BIT] = erratumMode_q;
      end
      if (selCtrl) rdMux[`CTRL_BUSOFF_MSK_BIT] = busOffMask_q;
      if (selErrStat) begin
         rdMux[`ERRSTAT_BUSOFF_FLAG_BIT] = busOffFlag_q;
         rdMux[`ERRSTAT_FLT_LO +: 2] = faultConf_q;
      end
      if (selIrqSt) rdMux[1:0] = irqStatus_q;
      if (selIrqMsk) rdMux[1:0] = irqMask_q;
   end

   // read data captured in the setup cycle of a mapped transfer so it is valid in access
   always_ff @(posedge clk) begin
      if (rst) rdata_q <= 32'h0000_0000;
      else if (psel && !penable && regHit) rdata_q <= rdMux;
   end
   assign prdata = rdata_q;

   // busoff_irq_mask gates the flag onto the request line
   assign busOffIrq = busOffFlag_q && busOffMask_q;
   assign irq = |(irqStatus_q & irqMask_q);
endmodule

// ### verification/busoff_ctrl_asserts.sv
// checker for the bus-off control slice ports
`timescale 1ns/1ps
module busoff_ctrl_asserts (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // apb
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // events and interrupt
   input wire logic busOffEnter,
   input wire logic busOffIrq
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   logic maskOn_q;
   wire wrAcc = psel && penable && pwrite;
   // shadow of the bus-off mask, so gating can be judged from the pins alone
   always_ff @(posedge clk) begin
      if (rst) maskOn_q <= 1'b0;
      else if (wrAcc && paddr == 12'h004) maskOn_q <= pwdata[15];
   end
   zero_wait_a: assert property (pready) else $error("pready low");
   bad_addr_a: assert property (psel && penable && paddr > 12'h010 |-> pslverr)
      else $error("unmapped access not refused");
   good_addr_a: assert property (psel && penable && paddr <= 12'h010 && paddr[1:0] == 2'h0
      |-> !pslverr) else $error("mapped access refused");
   mask_gate_a: assert property (!maskOn_q |-> !busOffIrq) else $error("masked irq");
   irq_raise_a: assert property (busOffEnter && maskOn_q |-> ##[1:2] busOffIrq)
      else $error("no irq on bus-off");
   flag_clear_a: assert property (wrAcc && paddr == 12'h008 && pwdata[2] && !busOffEnter
      |=> !busOffIrq) else $error("flag clear kept irq");
   no_echo_a: assert property ($rose(busOffIrq) |-> $past(busOffEnter) ||
      $past(busOffEnter, 2) || $past(wrAcc)) else $error("irq without cause");
   rd_hold_a: assert property (!psel && !$past(rst) |-> $stable(prdata))
      else $error("read data moved");
   reset_quiet_a: assert property (@(posedge clk) disable iff (1'b0)
      rst |=> !busOffIrq && prdata == 32'h0) else $error("outputs not cleared");
   cover property (busOffEnter && maskOn_q);
   cover property (wrAcc && paddr == 12'h000 && pwdata[0]);
   cover property (wrAcc && paddr == 12'h008 && pwdata[2]);
   cover property (wrAcc && paddr == 12'h000 && pwdata[1:0] == 2'h3);
endmodule
bind can_busoff_soft_reset_control busoff_ctrl_asserts chk (.clk, .rst, .psel, .penable,
   .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .busOffEnter, .busOffIrq);

// ### verification/can_engine_model.sv
// protocol engine and chip reset source seen by the slice
`timescale 1ns/1ps
module can_engine_model (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // commands from the bench
   input wire logic cmdBusOff,
   input wire logic cmdPassive,
   input wire logic cmdChip,
   // toward the slice
   output logic busOffEnter,
   output logic errorPassive,
   output logic globalSoftReset
);
   // events leave on a clock edge so the slice samples them cleanly
   always_ff @(posedge clk) begin
      busOffEnter <= !rst && cmdBusOff;
      errorPassive <= !rst && cmdPassive;
      globalSoftReset <= !rst && cmdChip;
   end
endmodule

// ### verification/can_busoff_soft_reset_control_tb.sv
// self-checking bench for the bus-off control slice
`timescale 1ns/1ps
module can_busoff_soft_reset_control_tb;
   logic clk, rst, psel, penable, pwrite, pready, pslverr, err, busOffIrq, irq;
   logic busOffEnter, errorPassive, globalSoftReset, cmdBusOff, cmdPassive, cmdChip;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   int nErrors = 0, totalChecks = 0, polls;
   typedef struct {logic [11:0] a; logic w; logic [31:0] d; logic [31:0] x; logic e;} row_t;
   row_t rows[9] = '{'{12'h004, 1, 32'h8000, 0, 0}, '{12'h004, 0, 0, 32'h8000, 0},
      '{12'h010, 1, 32'h3, 0, 0}, '{12'h010, 0, 0, 32'h3, 0}, '{12'h008, 0, 0, 0, 0},
      '{12'h00c, 0, 0, 0, 0}, '{12'h000, 0, 0, 0, 0}, '{12'h014, 0, 0, 0, 1},
      '{12'h006, 1, 32'h1, 0, 1}};
   can_busoff_soft_reset_control DUT (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .busOffEnter, .errorPassive, .globalSoftReset, .busOffIrq, .irq);
   can_engine_model engine (.clk, .rst, .cmdBusOff, .cmdPassive, .cmdChip, .busOffEnter,
      .errorPassive, .globalSoftReset);
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      totalChecks++;
      if (g !== e) begin
         nErrors++;
         $display("BAD %0t got %h want %h", $time, g, e);
      end
   endtask
   // one apb transfer; pready is waited for, never assumed
   task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
      @(posedge clk);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 0;
      penable <= 0;
   endtask
   task automatic busOff();
      cmdBusOff <= 1;
      @(posedge clk);
      cmdBusOff <= 0;
      repeat (3) @(posedge clk);
   endtask
   // poll the soft-reset bit, then the state, as the host must
   task automatic settle();
      polls = 0;
      do begin apb(12'h000, 0, 0); polls++; end while (rd[0] === 1'b1 && polls < 40);
      chk(polls > 1, 1);
      repeat (4) @(posedge clk);
      do apb(12'h008, 0, 0); while (rd[5:4] !== 2'h0 && polls++ < 40);
      chk(rd[5:4], 2'h0);
   endtask
   task automatic endSim();
      if (nErrors == 0 && totalChecks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      clk = 0;
      forever #2 clk = ~clk;
   end
   initial begin
      repeat (20000) @(posedge clk);
      nErrors++;
      endSim();
   end
   initial begin
      rst = 1'b1;
      {psel, penable, pwrite, paddr, pwdata, cmdBusOff, cmdPassive, cmdChip} = '0;
      repeat (8) @(posedge clk);
      rst <= 0;
      chk({busOffIrq, irq}, 0);
      chk(prdata, 0);
      foreach (rows[i]) begin
         apb(rows[i].a, rows[i].w, rows[i].d);
         chk(err, rows[i].e);
         if (!rows[i].w && !rows[i].e) chk(rd, rows[i].x);
      end
      cmdPassive <= 1;
      repeat (3) @(posedge clk);
      apb(12'h008, 0, 0);
      chk(rd[5:4], 2'h1);
      cmdPassive <= 0;
      busOff();
      chk({busOffIrq, irq}, 2'h3);
      apb(12'h008, 0, 0);
      chk({rd[5:4], rd[2]}, 3'h7);
      apb(12'h00c, 0, 0);
      chk(rd[0], 1);
      apb(12'h00c, 0, 0);
      chk({rd[0], irq}, 0);
      apb(12'h008, 1, 32'h4);
      @(posedge clk);
      chk(busOffIrq, 0);
      apb(12'h004, 1, 0);
      apb(12'h000, 1, 32'h1);
      settle();
      chk(rd[2], 0);
      apb(12'h008, 1, 32'h4);
      apb(12'h004, 1, 32'h8000);
      @(posedge clk);
      chk({busOffIrq, irq}, 2'h1);
      apb(12'h00c, 0, 0);
      @(posedge clk);
      chk({rd[1], irq}, 2'h2);
      // erratum emulation: the echo re-raises the flag, the ordered host steps absorb it
      apb(12'h004, 1, 0);
      apb(12'h000, 1, 32'h3);
      settle();
      chk(rd[2], 1);
      apb(12'h008, 1, 32'h4);
      apb(12'h008, 0, 0);
      chk({rd[5:4], rd[2]}, 3'h0);
      apb(12'h004, 1, 32'h8000);
      @(posedge clk);
      chk(busOffIrq, 0);
      busOff();
      chk(busOffIrq, 1);
      // a real bus-off must hold even with erratum emulation on
      apb(12'h008, 0, 0);
      chk(rd[5:4], 2'h3);
      apb(12'h000, 1, 0);
      apb(12'h010, 1, 0);
      apb(12'h00c, 0, 0);
      cmdChip <= 1;
      @(posedge clk);
      cmdChip <= 0;
      settle();
      chk(irq, 0);
      apb(12'h00c, 0, 0);
      chk(rd[1], 1);
      // reset in mid-run clears outputs and registers
      rst <= 1'b1;
      @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      chk({busOffIrq, irq}, 0);
      chk(prdata, 0);
      apb(12'h004, 0, 0);
      chk(rd, 0);
      endSim();
   end
endmodule
